// [pkg/prs_consts.svh]
`ifndef PRS_CONSTS_SVH
`define PRS_CONSTS_SVH

`define PRS_PC_W 21
`define PRS_SP_W 5
`define PRS_STK_DEPTH 31
`define PRS_SP_FULL 5'h1f
`define PRS_SP_EMPTY 5'h00
`define PRS_VEC_RESET 21'h000000
`define PRS_VEC_HIGH 21'h000008
`define PRS_VEC_LOW 21'h000018
`define PRS_PC_STEP 21'h000002
`define PRS_IMPL_BYTES 21'h010000

`define PRS_OFS_PCL 8'h00
`define PRS_OFS_LATH 8'h04
`define PRS_OFS_LATU 8'h08
`define PRS_OFS_SPR 8'h0c
`define PRS_OFS_TOP_OF_STACK_LOW 8'h10
`define PRS_OFS_TOP_OF_STACK_HIGH 8'h14
`define PRS_OFS_TOP_OF_STACK_UPPER 8'h18
`define PRS_OFS_CTRL 8'h1c

`define PRS_SPR_FULL_BIT 7
`define PRS_SPR_UNF_BIT 6
`define PRS_CTRL_ENA_BIT 0
`define PRS_CTRL_PUSH_BIT 1
`define PRS_CTRL_POP_BIT 2
`define PRS_CTRL_ENA_RESET 1'b1
`define PRS_LAT_RESET 8'h00

`define PRS_RESP_OKAY 2'h0
`define PRS_RESP_SLVERR 2'h2

`endif

// [pkg/prs_pkg.sv]
`default_nettype none
package prs_pkg;
    typedef logic [20:0] prs_pc_t;
    typedef logic [4:0] prs_sp_t;
    // which stack action the core takes this cycle
    typedef enum {PRS_OP_NONE, PRS_OP_PUSH, PRS_OP_POP} prs_op_e;
endpackage
`default_nettype wire

// [pkg/prs_stack_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface prs_stack_if;
    import prs_pkg::*;
    logic we;
    prs_sp_t waddr;
    prs_pc_t wdata;
    prs_sp_t raddr;
    prs_pc_t rdata;
    modport ctrl(output we, output waddr, output wdata, output raddr,
        input rdata);
    modport store(input we, input waddr, input wdata, input raddr,
        output rdata);
endinterface
`default_nettype wire

// [rtl/prs_stack_mem.sv]
`timescale 1ns/10ps
`default_nettype none
`include "prs_consts.svh"
module prs_stack_mem #(
    parameter int DEPTH = `PRS_STK_DEPTH
) (
    input wire logic clk,
    prs_stack_if.store port
);
    import prs_pkg::*;
    prs_pc_t mem [DEPTH];
    prs_pc_t rdataD;
    prs_pc_t rdataQ;

    // pointer n lives in word n-1; pointer zero has no storage
    always_comb begin
        rdataD = '0;
        if (port.we && port.waddr == port.raddr) begin
            rdataD = port.wdata; // write-through keeps top in step
        end else if (port.raddr != '0) begin
            rdataD = mem[port.raddr - 5'h01];
        end
    end

    // storage and registered read word
    always_ff @(posedge clk) begin
        if (port.we && port.waddr != '0) begin
            mem[port.waddr - 5'h01] <= port.wdata;
        end
        rdataQ <= rdataD;
    end

    assign port.rdata = rdataQ;
endmodule
`default_nettype wire

// [rtl/prs_fetch_gate.sv]
`timescale 1ns/10ps
`default_nettype none
`include "prs_consts.svh"
module prs_fetch_gate #(
    parameter logic [20:0] IMPL_BYTES = `PRS_IMPL_BYTES
) (
    input wire logic clk,
    input wire logic rst,
    input wire prs_pkg::prs_pc_t fetchAddr,
    input wire logic [15:0] fetchData,
    output logic [15:0] instrWord
);
    import prs_pkg::*;
    logic [15:0] instrD;
    logic [15:0] instrQ;

    // beyond the fitted array the word reads as all zeros, a no-op
    always_comb begin
        instrD = (fetchAddr >= IMPL_BYTES) ? 16'h0000 : fetchData;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            instrQ <= 16'h0000;
        end else begin
            instrQ <= instrD;
        end
    end

    assign instrWord = instrQ;
endmodule
`default_nettype wire

// [rtl/prs_pc_stack.sv]
`timescale 1ns/10ps
`default_nettype none
`include "prs_consts.svh"
module prs_pc_stack #(
    parameter logic [20:0] IMPL_BYTES = `PRS_IMPL_BYTES
) (
    input wire logic clk,
    input wire logic rst,
    // register bus
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // decoder and interrupt logic
    input wire logic resetOther,
    input wire logic seqAdvance,
    input wire logic jumpLoad,
    input wire logic callPush,
    input wire prs_pkg::prs_pc_t jumpTarget,
    input wire logic retPop,
    input wire logic intAck,
    input wire logic intHigh,
    input wire logic wakeWdt,
    input wire logic wakeInt,
    input wire logic highPriGlobalEnable,
    input wire logic lowPriGlobalEnable,
    // program memory fetch
    output prs_pkg::prs_pc_t fetchAddr,
    input wire logic [15:0] fetchData,
    output logic [15:0] instrWord,
    output logic stackResetReq,
    output logic stackFullFlag,
    output logic stackUnderflowFlag
);
    import prs_pkg::*;

    prs_stack_if stk();

    // counter, latches, pointer, flags and reset enable
    prs_pc_t pcQ, pcD;
    logic [7:0] pcHighLatchQ, pcHighLatchD;
    logic [4:0] pcUpperLatchQ, pcUpperLatchD;
    prs_sp_t spQ, spD;
    logic fullQ, fullD;
    logic unfQ, unfD;
    logic enaQ, enaD;
    logic stkRstQ, stkRstD;

    // bus handshake state
    logic awreadyQ, awreadyD;
    logic bvalidQ, bvalidD;
    logic [1:0] brespQ, brespD;
    logic arreadyQ, arreadyD;
    logic rvalidQ, rvalidD;
    logic [1:0] rrespQ, rrespD;
    logic [31:0] rdataQ, rdataD;

    logic wrFire;
    logic rdFire;
    logic wrLane;
    logic [7:0] wByte;
    logic wrMapped;
    logic rdMapped;
    logic [7:0] rdByte;
    prs_pc_t tos;
    prs_pc_t pushVal;
    prs_op_e op;
    logic opFromCore;
    logic swPush;
    logic swPop;

    prs_stack_mem #(
        .DEPTH(`PRS_STK_DEPTH)
    ) u_mem (
        .clk(clk),
        .port(stk)
    );

    prs_fetch_gate #(
        .IMPL_BYTES(IMPL_BYTES)
    ) u_gate (
        .clk(clk),
        .rst(rst),
        .fetchAddr(pcQ),
        .fetchData(fetchData),
        .instrWord(instrWord)
    );

    // pointer zero reads as an empty top
    assign tos = (spQ == `PRS_SP_EMPTY) ? '0 : stk.rdata;
    assign wrFire = awreadyQ && s_axi_awvalid && s_axi_wvalid;
    assign rdFire = arreadyQ && s_axi_arvalid;
    assign wrLane = s_axi_wstrb[0];
    assign wByte = s_axi_wdata[7:0];

    // address decode shared by both channels
    always_comb begin
        wrMapped = 1'b1;
        case (s_axi_awaddr)
            `PRS_OFS_PCL, `PRS_OFS_LATH, `PRS_OFS_LATU, `PRS_OFS_SPR,
            `PRS_OFS_TOP_OF_STACK_LOW, `PRS_OFS_TOP_OF_STACK_HIGH, `PRS_OFS_TOP_OF_STACK_UPPER,
            `PRS_OFS_CTRL: wrMapped = 1'b1;
            default: wrMapped = 1'b0;
        endcase
        rdMapped = 1'b1;
        case (s_axi_araddr)
            `PRS_OFS_PCL: rdByte = pcQ[7:0];
            `PRS_OFS_LATH: rdByte = pcHighLatchQ;
            `PRS_OFS_LATU: rdByte = {3'h0, pcUpperLatchQ};
            `PRS_OFS_SPR: rdByte = {fullQ, unfQ, 1'b0, spQ};
            `PRS_OFS_TOP_OF_STACK_LOW: rdByte = tos[7:0];
            `PRS_OFS_TOP_OF_STACK_HIGH: rdByte = tos[15:8];
            `PRS_OFS_TOP_OF_STACK_UPPER: rdByte = {3'h0, tos[20:16]};
            `PRS_OFS_CTRL: rdByte = {7'h00, enaQ};
            default: begin
                rdByte = 8'h00;
                rdMapped = 1'b0;
            end
        endcase
    end

    // bus channels: one write and one read in flight, ready from flops
    always_comb begin
        awreadyD = 1'b0;
        bvalidD = bvalidQ;
        brespD = brespQ;
        arreadyD = 1'b0;
        rvalidD = rvalidQ;
        rrespD = rrespQ;
        rdataD = rdataQ;
        if (s_axi_awvalid && s_axi_wvalid && !awreadyQ && !bvalidQ) begin
            awreadyD = 1'b1;
        end
        if (wrFire) begin
            bvalidD = 1'b1;
            brespD = wrMapped ? `PRS_RESP_OKAY : `PRS_RESP_SLVERR;
        end else if (bvalidQ && s_axi_bready) begin
            bvalidD = 1'b0;
        end
        if (s_axi_arvalid && !arreadyQ && !rvalidQ) begin
            arreadyD = 1'b1;
        end
        if (rdFire) begin
            rvalidD = 1'b1;
            rrespD = rdMapped ? `PRS_RESP_OKAY : `PRS_RESP_SLVERR;
            rdataD = {24'h000000, rdByte};
        end else if (rvalidQ && s_axi_rready) begin
            rvalidD = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            awreadyQ <= 1'b0;
            bvalidQ <= 1'b0;
            brespQ <= `PRS_RESP_OKAY;
            arreadyQ <= 1'b0;
            rvalidQ <= 1'b0;
            rrespQ <= `PRS_RESP_OKAY;
            rdataQ <= 32'h00000000;
        end else begin
            awreadyQ <= awreadyD;
            bvalidQ <= bvalidD;
            brespQ <= brespD;
            arreadyQ <= arreadyD;
            rvalidQ <= rvalidD;
            rrespQ <= rrespD;
            rdataQ <= rdataD;
        end
    end

    // counter and stack: bus write first, core action on top of it
    always_comb begin
        pcD = pcQ;
        pcHighLatchD = pcHighLatchQ;
        pcUpperLatchD = pcUpperLatchQ;
        spD = spQ;
        fullD = fullQ;
        unfD = unfQ;
        enaD = enaQ;
        stkRstD = 1'b0;
        stk.we = 1'b0;
        stk.waddr = spQ;
        stk.wdata = tos;
        op = PRS_OP_NONE;
        opFromCore = 1'b1;
        pushVal = pcQ;
        swPush = 1'b0;
        swPop = 1'b0;
        if (wrFire && wrLane) begin
            case (s_axi_awaddr)
                `PRS_OFS_PCL: begin
                    // latches ride in with the low byte
                    pcD = {pcUpperLatchQ, pcHighLatchQ, wByte};
                end
                `PRS_OFS_LATH: pcHighLatchD = wByte;
                `PRS_OFS_LATU: pcUpperLatchD = wByte[4:0];
                `PRS_OFS_SPR: begin
                    spD = wByte[4:0];
                    // this write only clears flags, never sets them
                    if (!wByte[`PRS_SPR_FULL_BIT]) begin
                        fullD = 1'b0;
                    end
                    if (!wByte[`PRS_SPR_UNF_BIT]) begin
                        unfD = 1'b0;
                    end
                end
                `PRS_OFS_TOP_OF_STACK_LOW: begin
                    stk.we = (spQ != `PRS_SP_EMPTY);
                    stk.wdata = {tos[20:8], wByte};
                end
                `PRS_OFS_TOP_OF_STACK_HIGH: begin
                    stk.we = (spQ != `PRS_SP_EMPTY);
                    stk.wdata = {tos[20:16], wByte, tos[7:0]};
                end
                `PRS_OFS_TOP_OF_STACK_UPPER: begin
                    stk.we = (spQ != `PRS_SP_EMPTY);
                    stk.wdata = {wByte[4:0], tos[15:0]};
                end
                `PRS_OFS_CTRL: begin
                    enaD = wByte[`PRS_CTRL_ENA_BIT];
                    swPush = wByte[`PRS_CTRL_PUSH_BIT];
                    swPop = wByte[`PRS_CTRL_POP_BIT];
                end
                default: pcD = pcQ;
            endcase
        end
        // a read of the low byte snapshots the upper counter bits
        if (rdFire && s_axi_araddr == `PRS_OFS_PCL) begin
            pcHighLatchD = pcQ[15:8];
            pcUpperLatchD = pcQ[20:16];
        end
        // core actions, one per cycle in this priority
        if (resetOther) begin
            pcD = `PRS_VEC_RESET; // flags kept
            spD = `PRS_SP_EMPTY;
        end else if (wakeInt && (highPriGlobalEnable || lowPriGlobalEnable))
        begin
            op = PRS_OP_PUSH; // resume point saved
            pushVal = pcQ + `PRS_PC_STEP;
            pcD = highPriGlobalEnable ? `PRS_VEC_HIGH : `PRS_VEC_LOW;
        end else if (wakeWdt || wakeInt) begin
            pcD = pcQ + `PRS_PC_STEP;
        end else if (intAck) begin
            op = PRS_OP_PUSH;
            pcD = intHigh ? `PRS_VEC_HIGH : `PRS_VEC_LOW;
        end else if (callPush) begin
            op = PRS_OP_PUSH;
            pushVal = pcQ + `PRS_PC_STEP; // next instruction
            pcD = jumpTarget;
        end else if (retPop) begin
            op = PRS_OP_POP;
        end else if (jumpLoad) begin
            pcD = jumpTarget; // latches not used
        end else if (seqAdvance) begin
            pcD = pcQ + `PRS_PC_STEP;
        end else if (swPush) begin
            op = PRS_OP_PUSH;
            opFromCore = 1'b0;
        end else if (swPop) begin
            op = PRS_OP_POP;
            opFromCore = 1'b0;
        end
        case (op)
            PRS_OP_PUSH: begin
                if (spQ == `PRS_SP_FULL) begin
                    fullD = 1'b1; // nothing overwritten
                    stkRstD = enaQ;
                end else begin
                    spD = spQ + 5'h01; // bump then write
                    stk.we = 1'b1;
                    stk.waddr = spQ + 5'h01;
                    stk.wdata = pushVal;
                    if (spQ + 5'h01 == `PRS_SP_FULL) begin
                        fullD = 1'b1;
                        stkRstD = enaQ;
                    end
                end
            end
            PRS_OP_POP: begin
                if (spQ == `PRS_SP_EMPTY) begin
                    unfD = 1'b1;
                    stkRstD = enaQ;
                    if (opFromCore) begin
                        pcD = `PRS_VEC_RESET;
                    end
                end else begin
                    if (opFromCore) begin
                        pcD = tos; // read before the drop
                    end
                    spD = spQ - 5'h01;
                end
            end
            default: op = PRS_OP_NONE;
        endcase
        // stack event reset: flags stay, pointer and counter restart
        if (stkRstD) begin
            spD = `PRS_SP_EMPTY;
            pcD = `PRS_VEC_RESET;
        end
        pcD[0] = 1'b0;
        stk.raddr = spD;
    end

    // power-on reset clears counter, latches, pointer and sticky flags; the reset enable comes up set
    always_ff @(posedge clk) begin
        if (rst) begin
            pcQ <= `PRS_VEC_RESET;
            pcHighLatchQ <= `PRS_LAT_RESET;
            pcUpperLatchQ <= 5'h00;
            spQ <= `PRS_SP_EMPTY;
            fullQ <= 1'b0;
            unfQ <= 1'b0;
            enaQ <= `PRS_CTRL_ENA_RESET;
            stkRstQ <= 1'b0;
        end else begin
            pcQ <= pcD;
            pcHighLatchQ <= pcHighLatchD;
            pcUpperLatchQ <= pcUpperLatchD;
            spQ <= spD;
            fullQ <= fullD;
            unfQ <= unfD;
            enaQ <= enaD;
            stkRstQ <= stkRstD;
        end
    end

    assign s_axi_awready = awreadyQ;
    assign s_axi_wready = awreadyQ;
    assign s_axi_bvalid = bvalidQ;
    assign s_axi_bresp = brespQ;
    assign s_axi_arready = arreadyQ;
    assign s_axi_rvalid = rvalidQ;
    assign s_axi_rresp = rrespQ;
    assign s_axi_rdata = rdataQ;
    assign fetchAddr = pcQ;
    assign stackResetReq = stkRstQ;
    assign stackFullFlag = fullQ;
    assign stackUnderflowFlag = unfQ;
endmodule
`default_nettype wire

// [tb/prs_pc_stack_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module prs_pc_stack_asserts #(
    parameter logic [20:0] IMPL_BYTES = 21'h010000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic resetOther,
    input wire logic seqAdvance,
    input wire logic jumpLoad,
    input wire logic callPush,
    input wire prs_pkg::prs_pc_t jumpTarget,
    input wire logic retPop,
    input wire logic intAck,
    input wire logic intHigh,
    input wire logic wakeWdt,
    input wire logic wakeInt,
    input wire logic highPriGlobalEnable,
    input wire logic lowPriGlobalEnable,
    input wire prs_pkg::prs_pc_t fetchAddr,
    input wire logic [15:0] fetchData,
    input wire logic [15:0] instrWord,
    input wire logic stackFullFlag,
    input wire logic stackUnderflowFlag
);
    import prs_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // wake kinds and higher-priority core events
    logic anyEn;
    logic wakeVec;
    logic busy;
    prs_pc_t pc2;
    assign anyEn = highPriGlobalEnable | lowPriGlobalEnable;
    assign wakeVec = wakeInt & anyEn;
    assign busy = resetOther | wakeWdt | wakeInt | intAck;
    assign pc2 = fetchAddr + 21'h000002;
    sequence plain_wake;
        !resetOther && !wakeVec && (wakeWdt || wakeInt);
    endsequence
    sequence vec_wake;
        !resetOther && wakeVec;
    endsequence
    other_reset_a: assert property (resetOther |=> fetchAddr == 21'h0)
        else $error("pc not at zero after reset");
    seq_step_a: assert property (seqAdvance && !busy && !callPush && !retPop
        && !jumpLoad |=> fetchAddr == $past(pc2))
        else $error("pc did not step by two");
    jump_load_a: assert property (jumpLoad && !busy && !callPush && !retPop
        |=> fetchAddr == ($past(jumpTarget) & 21'h1ffffe))
        else $error("jump target not loaded");
    call_load_a: assert property (callPush && !busy |=> fetchAddr == 21'h0
        || fetchAddr == ($past(jumpTarget) & 21'h1ffffe))
        else $error("call target not loaded");
    int_vector_a: assert property (intAck && !resetOther && !wakeWdt
        && !wakeInt |=> fetchAddr == ($past(intHigh) ? 21'h8 : 21'h18))
        else $error("interrupt vector wrong");
    wake_step_a: assert property (plain_wake |=> fetchAddr == $past(pc2))
        else $error("wake did not resume at pc plus two");
    wake_vector_a: assert property (vec_wake |=> fetchAddr ==
        ($past(highPriGlobalEnable) ? 21'h8 : 21'h18))
        else $error("wake vector wrong");
    fetch_zero_a: assert property (fetchAddr >= IMPL_BYTES
        |=> instrWord == 16'h0000)
        else $error("fetch above memory not zero");
    fetch_pass_a: assert property (fetchAddr < IMPL_BYTES
        |=> instrWord == $past(fetchData))
        else $error("fetch word not passed");
    full_sticky_a: assert property (stackFullFlag
        && !(s_axi_awvalid && s_axi_awready) |=> stackFullFlag)
        else $error("full flag dropped");
    unf_sticky_a: assert property (stackUnderflowFlag
        && !(s_axi_awvalid && s_axi_awready) |=> stackUnderflowFlag)
        else $error("underflow flag dropped");
endmodule
bind prs_pc_stack prs_pc_stack_asserts #(.IMPL_BYTES(IMPL_BYTES))
    prs_pc_stack_asserts_i (.clk, .rst, .s_axi_awvalid, .s_axi_awready,
    .resetOther, .seqAdvance, .jumpLoad, .callPush, .jumpTarget, .retPop,
    .intAck, .intHigh, .wakeWdt, .wakeInt, .highPriGlobalEnable,
    .lowPriGlobalEnable, .fetchAddr, .fetchData, .instrWord, .stackFullFlag,
    .stackUnderflowFlag);
`default_nettype wire

// [tb/prs_core_mem.sv]
`timescale 1ns/10ps
`default_nettype none
module prs_core_mem (
    input wire prs_pkg::prs_pc_t fetchAddr,
    output logic [15:0] fetchData
);
    import prs_pkg::*;
    // answers everywhere, so only the gate can blank the top
    assign fetchData = fetchAddr[16:1] ^ 16'ha5c3;
endmodule
`default_nettype wire

// [tb/program_counter_return_stack_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module program_counter_return_stack_tb;
    import prs_pkg::*;
    logic clk = 1'b0, rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic resetOther = 1'b0, seqAdvance = 1'b0, jumpLoad = 1'b0;
    logic callPush = 1'b0, retPop = 1'b0, intAck = 1'b0, intHigh = 1'b0;
    logic wakeWdt = 1'b0, wakeInt = 1'b0;
    // enables stay low around stack register access
    logic highPriGlobalEnable = 1'b0, lowPriGlobalEnable = 1'b0;
    logic stackResetReq, stackFullFlag, stackUnderflowFlag;
    logic [15:0] fetchData, instrWord;
    prs_pc_t jumpTarget = 21'h0, fetchAddr;
    int n_mismatch = 0, cmp_count = 0, cyc = 0, nRst = 0;
    prs_pc_stack prs_pc_stack_i (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .resetOther,
        .seqAdvance, .jumpLoad, .callPush, .jumpTarget, .retPop, .intAck,
        .intHigh, .wakeWdt, .wakeInt, .highPriGlobalEnable,
        .lowPriGlobalEnable, .fetchAddr, .fetchData, .instrWord,
        .stackResetReq, .stackFullFlag, .stackUnderflowFlag);
    prs_core_mem prs_core_mem_i (.fetchAddr, .fetchData);
    always #25 clk = ~clk;
    // hang guard and reset pulse tally
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (stackResetReq === 1'b1) nRst <= nRst + 1;
        if (cyc == 8000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic pc(input prs_pc_t e);
        chk(34'(fetchAddr), 34'(e));
    endtask
    // aw and w offered together; bready held until bvalid seen
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
            input logic [1:0] er = 2'h0);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge clk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(34'(s_axi_bresp), 34'(er));
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e,
            input logic [1:0] er = 2'h0);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk({s_axi_rresp, s_axi_rdata}, {er, 24'h0, e});
    endtask
    // one-cycle core event, outputs settled on return
    task automatic op(input int k, input prs_pc_t t = 21'h0);
        @(posedge clk);
        jumpTarget <= t;
        case (k)
            0: seqAdvance <= 1'b1;
            1: jumpLoad <= 1'b1;
            2: callPush <= 1'b1;
            3: retPop <= 1'b1;
            4: intAck <= 1'b1;
            5: wakeWdt <= 1'b1;
            6: wakeInt <= 1'b1;
            default: resetOther <= 1'b1;
        endcase
        @(posedge clk);
        {seqAdvance, jumpLoad, callPush, retPop} <= 4'h0;
        {intAck, wakeWdt, wakeInt, resetOther} <= 4'h0;
        #1;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(8'h0c, 8'h00);
        rd(8'h1c, 8'h01);
        rd(8'h10, 8'h00);
        pc(21'h0);
        op(0);
        pc(21'h2);
        @(posedge clk);
        #1;
        chk(34'(instrWord), 34'ha5c2);
        wr(8'h04, 8'h12);
        wr(8'h08, 8'h01);
        wr(8'h00, 8'h35);
        pc(21'h011234);
        @(posedge clk);
        #1;
        chk(34'(instrWord), 34'h0);
        op(1, 21'h00abcd);
        pc(21'h00abcc);
        rd(8'h04, 8'h12);
        rd(8'h00, 8'hcc);
        rd(8'h04, 8'hab);
        rd(8'h08, 8'h00);
        wr(8'h04, 8'h77);
        op(2, 21'h000100);
        pc(21'h100);
        rd(8'h0c, 8'h01);
        rd(8'h10, 8'hce);
        rd(8'h14, 8'hab);
        op(3);
        pc(21'h00abce);
        rd(8'h0c, 8'h00);
        rd(8'h04, 8'h77);
        for (int i = 0; i < 2; i++) begin
            intHigh <= (i == 0);
            op(4);
            pc(i ? 21'h18 : 21'h8);
            rd(8'h0c, 8'(i + 1));
        end
        wr(8'h0c, 8'h02);
        rd(8'h10, 8'h08);
        wr(8'h10, 8'h44);
        rd(8'h10, 8'h44);
        wr(8'h0c, 8'h01);
        rd(8'h10, 8'hce);
        wr(8'h1c, 8'h03);
        rd(8'h0c, 8'h02);
        rd(8'h10, 8'h18);
        wr(8'h1c, 8'h05);
        rd(8'h0c, 8'h01);
        wr(8'h1c, 8'h00);
        wr(8'h0c, 8'h00);
        op(3);
        pc(21'h0);
        rd(8'h0c, 8'h40);
        chk(34'(stackUnderflowFlag), 34'h1);
        op(7);
        rd(8'h0c, 8'h40);
        wr(8'h0c, 8'h00);
        rd(8'h0c, 8'h00);
        for (int i = 0; i < 31; i++) op(2, 21'h200 + 21'(4 * i));
        rd(8'h0c, 8'h9f);
        op(2, 21'h300);
        rd(8'h0c, 8'h9f);
        rd(8'h10, 8'h76);
        chk(34'(stackFullFlag), 34'h1);
        chk(34'(nRst), 34'h0);
        wr(8'h1c, 8'h01);
        wr(8'h0c, 8'h1e);
        op(2, 21'h400);
        pc(21'h0);
        rd(8'h0c, 8'h80);
        op(3);
        rd(8'h0c, 8'hc0);
        chk(34'(nRst), 34'h2);
        op(5);
        pc(21'h2);
        op(6);
        pc(21'h4);
        highPriGlobalEnable <= 1'b1;
        op(6);
        pc(21'h8);
        highPriGlobalEnable <= 1'b0;
        lowPriGlobalEnable <= 1'b1;
        op(6);
        pc(21'h18);
        lowPriGlobalEnable <= 1'b0;
        wr(8'h20, 8'h5a, 2'h2);
        rd(8'h20, 8'h00, 2'h2);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(8'h0c, 8'h00);
        pc(21'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
